// ### rtl/bsi_top.sv
`timescale 1ns/100ps
`include "bsi_map.svh"
module bsi_top #(
  parameter int BSR_LEN = 8,
  parameter logic [`BSI_ID_VER_W-1:0] ID_VERSION = 4'h1, // arbitrary value
  parameter logic [`BSI_ID_PART_W-1:0] ID_PART = 16'h5a5a, // arbitrary value
  parameter logic [`BSI_ID_MFR_W-1:0] ID_MAKER = 11'h2aa // arbitrary value
) (
  // system side
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sys_ce,
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] core_oe,
  input wire logic [BSR_LEN-1:0] pad_in,
  output logic [BSR_LEN-1:0] pad_out,
  output logic [BSR_LEN-1:0] pad_oe,
  output logic test_mode,
  // test port side, clocked by tck
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdi,
  input wire logic tap_reset,
  input wire logic capture_ir,
  input wire logic shift_ir,
  input wire logic update_ir,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  output logic tdo,
  output logic tdo_oe
);

  // identification word, built from the field parameters
  // maker code is the parity-stripped form, eleven bits wide
  localparam logic [`BSI_ID_W-1:0] ID_WORD =
    {ID_VERSION, ID_PART, ID_MAKER, `BSI_ID_MARK};

  // tck domain state
  bsi_pkg::bsi_instr_t ir_sh_q; // instruction shift stage
  bsi_pkg::bsi_instr_t ir_sh_d;
  bsi_pkg::bsi_instr_t ir_q; // current instruction
  bsi_pkg::bsi_instr_t ir_d;
  logic [`BSI_ID_W-1:0] id_sh_q;
  logic [`BSI_ID_W-1:0] id_sh_d;
  logic byp_q;
  logic byp_d;
  logic [BSR_LEN-1:0] bsr_sh_q;
  logic [BSR_LEN-1:0] bsr_sh_d;
  logic [BSR_LEN-1:0] bsr_upd_q;
  logic [BSR_LEN-1:0] bsr_upd_d;
  logic tdo_q;
  logic tdo_oe_q;

  // pad levels brought into the tck domain before capture
  logic [BSR_LEN-1:0] pin_tck;

  bsi_sync #(
    .W(BSR_LEN)
  ) u_pin_sync (
    .clk(tck),
    .rst(~trst_n),
    .ce(1'b1),
    .d(pad_in),
    .q(pin_tck)
  );

  // instruction decode
  // spare codes fall to bypass so a stray opcode never takes the pads
  wire op_extest = (ir_q == `BSI_OP_EXTEST);
  wire op_sample = (ir_q == `BSI_OP_SAMPLE);
  wire op_idcode = (ir_q == `BSI_OP_IDCODE);
  wire op_highz = (ir_q == `BSI_OP_HIGHZ);

  // everything else, high-z, bypass and the eleven spare codes, takes bypass
  wire sel_bsr = op_extest | op_sample;
  wire sel_id = op_idcode;
  wire sel_byp = ~sel_bsr & ~sel_id;

  bsi_pkg::bsi_sel_e sel;
  assign sel = sel_bsr ? bsi_pkg::BSI_SEL_BSR :
               sel_id ? bsi_pkg::BSI_SEL_ID :
               bsi_pkg::BSI_SEL_BYP;

  // instruction register next values
  // update acts on rising tck, half a cycle before the usual falling
  // latch; the instruction still changes only once per scan
  // capture loads the fixed pattern, shift moves lsb toward tdo
  assign ir_sh_d = capture_ir ? `BSI_IR_CAPTURE :
                   shift_ir ? {tdi, ir_sh_q[`BSI_IR_W-1:1]} :
                   ir_sh_q;

  // test-logic-reset forces idcode so a data scan reads the id
  assign ir_d = tap_reset ? `BSI_IR_RESET :
                update_ir ? ir_sh_q :
                ir_q;

  // instruction stages, port reset pin is asynchronous
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_q <= `BSI_IR_CAPTURE;
      ir_q <= `BSI_IR_RESET;
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
    end
  end

  // data register next values
  // each register moves only while it is selected, so the others
  // never disturb the path or the chip
  wire id_cap = capture_dr & sel_id;
  wire id_sft = shift_dr & sel_id;
  assign id_sh_d = id_cap ? ID_WORD :
                   id_sft ? {tdi, id_sh_q[`BSI_ID_W-1:1]} :
                   id_sh_q;

  wire byp_cap = capture_dr & sel_byp;
  wire byp_sft = shift_dr & sel_byp;
  assign byp_d = byp_cap ? `BSI_BYP_CAPTURE :
                 byp_sft ? tdi :
                 byp_q;

  wire bsr_cap = capture_dr & sel_bsr;
  wire bsr_sft = shift_dr & sel_bsr;
  wire bsr_upd = update_dr & sel_bsr;
  // capture takes live pad levels in both extest and sample
  assign bsr_sh_d = bsr_cap ? pin_tck :
                    bsr_sft ? {tdi, bsr_sh_q[BSR_LEN-1:1]} :
                    bsr_sh_q;
  // update stage lets sample preload values before extest
  assign bsr_upd_d = bsr_upd ? bsr_sh_q : bsr_upd_q;

  // data registers, rising tck
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      id_sh_q <= '0;
      byp_q <= 1'b0;
      bsr_sh_q <= '0;
      bsr_upd_q <= '0;
    end else begin
      id_sh_q <= id_sh_d;
      byp_q <= byp_d;
      bsr_sh_q <= bsr_sh_d;
      bsr_upd_q <= bsr_upd_d;
    end
  end

  // serial output
  logic dr_bit;
  always_comb begin
    case (sel)
      bsi_pkg::BSI_SEL_BSR: dr_bit = bsr_sh_q[0];
      bsi_pkg::BSI_SEL_ID: dr_bit = id_sh_q[0];
      bsi_pkg::BSI_SEL_BYP: dr_bit = byp_q;
      default: dr_bit = byp_q;
    endcase
  end

  // the falling edge after capture already lies in shift, so the
  // instruction path must be on tdo from the capture cycle on
  wire tdo_d = (capture_ir | shift_ir) ? ir_sh_q[0] : dr_bit;
  wire tdo_oe_d = shift_ir | shift_dr;

  // tdo changes on falling tck so the controller samples a settled bit
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // crossing into the system clock
  // mode bits and the update stage travel as one snapshot word; a
  // toggle flips whenever the snapshot moves, and the system side
  // takes the word only once the toggle has passed two flip-flops,
  // so it never loads a word while some of its bits still move
  localparam int VIEW_W = BSR_LEN + 2;
  logic [VIEW_W-1:0] view_d;
  logic [VIEW_W-1:0] view_q;
  logic view_tgl_d;
  logic view_tgl_q;

  // test-logic-reset drops both modes in the same tck cycle
  assign view_d = {op_highz & ~tap_reset, op_extest & ~tap_reset,
                   bsr_upd_q};
  assign view_tgl_d = (view_d != view_q) ? ~view_tgl_q : view_tgl_q;

  // snapshot and toggle, rising tck
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      view_q <= '0;
      view_tgl_q <= 1'b0;
    end else begin
      view_q <= view_d;
      view_tgl_q <= view_tgl_d;
    end
  end

  // toggle and port reset pin brought into the system clock
  logic [1:0] hs_sys;
  bsi_sync #(
    .W(2)
  ) u_hs_sync (
    .clk(clk_sys),
    .rst(sys_rst),
    .ce(sys_ce),
    .d({~trst_n, view_tgl_q}),
    .q(hs_sys)
  );
  wire port_rst_sys = hs_sys[1];
  wire view_tgl_sys = hs_sys[0];

  // a toggle edge means view_q has stood still for two system cycles;
  // limitation: tck must stay slower than three system cycles, and
  // snapshots that pile up while sys_ce is low may be missed
  logic tgl_seen_q;
  logic [VIEW_W-1:0] sys_view_q;
  wire view_new = view_tgl_sys ^ tgl_seen_q;

  // port reset clears the copy as it clears the tck side, since a
  // toggle cleared by it may leave no edge behind
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tgl_seen_q <= 1'b0;
      sys_view_q <= '0;
    end else if (sys_ce) begin
      tgl_seen_q <= view_tgl_sys;
      if (port_rst_sys) begin
        sys_view_q <= '0;
      end else if (view_new) begin
        sys_view_q <= view_q;
      end
    end
  end

  wire sys_extest = sys_view_q[BSR_LEN];
  wire sys_highz = sys_view_q[BSR_LEN+1];
  wire [BSR_LEN-1:0] sys_upd = sys_view_q[BSR_LEN-1:0];

  // pad drivers, system domain
  // per pad: extest drives the update stage, high-z floats the pad,
  // every other instruction leaves the core in charge
  logic [BSR_LEN-1:0] pad_out_d;
  logic [BSR_LEN-1:0] pad_oe_d;

  genvar p;
  generate
    for (p = 0; p < BSR_LEN; p++) begin : g_pad
      assign pad_out_d[p] = sys_extest ? sys_upd[p] : core_out[p];
      assign pad_oe_d[p] = sys_highz ? 1'b0 :
                           sys_extest ? 1'b1 :
                           core_oe[p];
    end
  endgenerate

  logic [BSR_LEN-1:0] pad_out_q;
  logic [BSR_LEN-1:0] pad_oe_q;
  logic test_mode_q;

  // outputs held while sys_ce is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      test_mode_q <= 1'b0;
    end else if (sys_ce) begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
      test_mode_q <= sys_extest | sys_highz;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign test_mode = test_mode_q;

endmodule

// ### rtl/bsi_map.svh
`ifndef BSI_MAP_SVH
`define BSI_MAP_SVH

// instruction register geometry and opcodes
`define BSI_IR_W 4
`define BSI_OP_EXTEST 4'h0
`define BSI_OP_SAMPLE 4'h1
`define BSI_OP_IDCODE 4'h2
`define BSI_OP_HIGHZ 4'h3
`define BSI_OP_BYPASS 4'hf

// fixed pattern loaded in instruction capture, two lsbs are 01
`define BSI_IR_CAPTURE 4'h1
// instruction taken after port reset
`define BSI_IR_RESET 4'h2

// identification register layout
`define BSI_ID_W 32
`define BSI_ID_VER_W 4
`define BSI_ID_PART_W 16
`define BSI_ID_MFR_W 11
`define BSI_ID_VER_LSB 28
`define BSI_ID_PART_LSB 12
`define BSI_ID_MFR_LSB 1
`define BSI_ID_MARK 1'h1

// value captured into the bypass stage
`define BSI_BYP_CAPTURE 1'h0

`endif

// ### rtl/bsi_pkg.sv
package bsi_pkg;

  // which test data register sits between tdi and tdo
  typedef enum logic [1:0] {
    BSI_SEL_BSR,
    BSI_SEL_ID,
    BSI_SEL_BYP
  } bsi_sel_e;

  typedef logic [3:0] bsi_instr_t;

endpackage

// ### rtl/bsi_sync.sv
`timescale 1ns/100ps
// two-stage level synchroniser, one chain per bit
module bsi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // first stage is read only by the second
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else if (ce) begin
          meta_q[i] <= d[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign q = sync_q;

endmodule

// ### sim/bsi_monitor.sv
`timescale 1ns/100ps
`include "bsi_map.svh"
// port watcher for the test port and the pads
module bsi_monitor #(
  parameter int BSR_LEN = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] core_oe,
  input wire logic [BSR_LEN-1:0] pad_out,
  input wire logic [BSR_LEN-1:0] pad_oe,
  input wire logic test_mode,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdi,
  input wire logic tap_reset,
  input wire logic capture_ir,
  input wire logic shift_ir,
  input wire logic update_ir,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic [3:0] sh_q;
  logic [3:0] cur_q;
  wire byp = !(cur_q inside {4'h0, 4'h1, 4'h2});
  // own shadow of the instruction so path checks need no design internals
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      sh_q <= 4'h0;
      cur_q <= `BSI_OP_IDCODE;
    end else begin
      if (shift_ir) sh_q <= {tdi, sh_q[3:1]};
      if (tap_reset) cur_q <= `BSI_OP_IDCODE;
      else if (update_ir) cur_q <= sh_q;
    end
  end
  sequence idle2;
    (!shift_ir && !shift_dr) [*2];
  endsequence
  sequence byp_cap;
    capture_dr && byp;
  endsequence
  chk_oe_shift:
  assert property (@(posedge tck) disable iff (!trst_n)
    shift_dr && $past(shift_dr) |-> tdo_oe) else $error("tdo idle in shift");
  chk_oe_idle:
  assert property (@(posedge tck) disable iff (!trst_n)
    idle2 |-> !tdo_oe) else $error("tdo driven when idle");
  chk_byp_zero:
  assert property (@(posedge tck) disable iff (!trst_n)
    byp_cap |=> !tdo) else $error("bypass capture not zero");
  chk_id_lsb:
  assert property (@(posedge tck) disable iff (!trst_n)
    capture_dr && cur_q == `BSI_OP_IDCODE |=> tdo) else $error("id bit0");
  chk_ir_cap:
  assert property (@(posedge tck) disable iff (!trst_n)
    capture_ir |=> tdo) else $error("ir capture lsb");
  chk_byp_delay:
  assert property (@(posedge tck) disable iff (!trst_n)
    shift_dr && byp |=> tdo == $past(tdi)) else $error("bypass delay");
  chk_pads_core:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    !test_mode && $past(!test_mode) && !$past(sys_rst) |->
    pad_oe == $past(core_oe) && pad_out == $past(core_out))
    else $error("pads not following core");
  chk_mode_pads:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    test_mode |-> pad_oe == '0 || pad_oe == '1) else $error("mixed enables");
endmodule
bind bsi_top bsi_monitor #(.BSR_LEN(BSR_LEN)) u_bsi_monitor (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .core_out(core_out),
  .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
  .test_mode(test_mode), .tck(tck), .trst_n(trst_n), .tdi(tdi),
  .tap_reset(tap_reset), .capture_ir(capture_ir), .shift_ir(shift_ir),
  .update_ir(update_ir), .capture_dr(capture_dr), .shift_dr(shift_dr),
  .tdo(tdo), .tdo_oe(tdo_oe));

// ### sim/bsi_ctl.sv
`timescale 1ns/100ps
// scan controller model; tck only runs inside operations
module bsi_ctl (
  output logic tck,
  output logic trst_n,
  output logic tdi,
  output logic tap_reset,
  output logic [2:0] ir_st,
  output logic [2:0] dr_st,
  input wire logic tdo
);
  initial begin
    {tck, tdi, ir_st, dr_st} = 8'h00;
    trst_n = 1'b0;
    tap_reset = 1'b1;
  end
  // flags move 5 ns after the fall, clear of both edges
  task automatic tick();
    #75 tck = 1'b1;
    #80 tck = 1'b0;
    #5;
  endtask
  // pin reset, then five cycles in test-logic-reset
  task automatic port_reset();
    trst_n = 1'b0;
    tap_reset = 1'b1;
    tick();
    trst_n = 1'b1;
    repeat (5) tick();
    tap_reset = 1'b0;
    tick();
  endtask
  // five tms-high cycles with the reset pin left released
  task automatic tms_reset();
    tap_reset = 1'b1;
    repeat (5) tick();
    tap_reset = 1'b0;
    tick();
  endtask
  // capture, shift n bits lsb first, update, one idle cycle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
    dout = 32'h0;
    {ir_st, dr_st} = ir ? 6'h20 : 6'h04;
    tick();
    {ir_st, dr_st} = ir ? 6'h10 : 6'h02;
    for (int i = 0; i < n; i++) begin
      tdi = din[i];
      #75 dout[i] = tdo;
      tck = 1'b1;
      #80 tck = 1'b0;
      #5;
    end
    tdi = !tdi; // released line must not show a stale bit
    {ir_st, dr_st} = ir ? 6'h08 : 6'h01;
    tick();
    {ir_st, dr_st} = 6'h00;
    tick();
  endtask
endmodule

// ### sim/boundary_scan_instr_idreg_bench.sv
`timescale 1ns/100ps
`include "bsi_map.svh"
module boundary_scan_instr_idreg_bench;
  localparam int N = 8;
  // identity fields below, values arbitrary
  localparam logic [31:0] ID = {4'h6, 16'h3c3c, 11'h155, `BSI_ID_MARK};
  logic clk_sys, sys_rst, test_mode, tck, trst_n, tdi, tap_reset, tdo;
  logic [2:0] ir_st, dr_st;
  logic [N-1:0] core_out, core_oe, pad_in, pad_out, pad_oe;
  logic [31:0] din, dout, pads;
  logic [3:0] op;
  int seed = 28829;
  int mismatches = 0;
  int tests_run = 0;
  bsi_top #(.BSR_LEN(N), .ID_VERSION(ID[31:28]), .ID_PART(ID[27:12]),
    .ID_MAKER(ID[11:1])) u_bsi_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sys_ce(1'b1), .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .test_mode(test_mode), .tck(tck),
    .trst_n(trst_n), .tdi(tdi), .tap_reset(tap_reset),
    .capture_ir(ir_st[2]), .shift_ir(ir_st[1]), .update_ir(ir_st[0]),
    .capture_dr(dr_st[2]), .shift_dr(dr_st[1]), .update_dr(dr_st[0]),
    .tdo(tdo), .tdo_oe());
  bsi_ctl u_bsi_ctl (.tck(tck), .trst_n(trst_n), .tdi(tdi),
    .tap_reset(tap_reset), .ir_st(ir_st), .dr_st(dr_st), .tdo(tdo));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = !clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // boundary register length for the two boundary opcodes, else 32
  function automatic int len(input logic [3:0] o);
    return (o == `BSI_OP_EXTEST || o == `BSI_OP_SAMPLE) ? N : 32;
  endfunction
  function automatic logic [31:0] want_dr(input logic [3:0] o,
      input logic [31:0] d);
    case (o)
      `BSI_OP_EXTEST, `BSI_OP_SAMPLE: want_dr = 32'(pad_in);
      `BSI_OP_IDCODE: want_dr = ID;
      default: want_dr = {d[30:0], `BSI_BYP_CAPTURE};
    endcase
  endfunction
  // pad data under high-z is left unchecked
  function automatic logic [31:0] want_pad(input logic [3:0] o,
      input logic [31:0] d);
    case (o)
      `BSI_OP_EXTEST: want_pad = 32'({1'b1, {N{1'b1}}, d[N-1:0]});
      `BSI_OP_HIGHZ: want_pad = 32'({1'b1, {N{1'b0}}, {N{1'b0}}});
      default: want_pad = 32'({1'b0, core_oe, core_out});
    endcase
  endfunction
  // watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    core_out = N'($random(seed));
    core_oe = N'($random(seed));
    pad_in = N'($random(seed));
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    u_bsi_ctl.port_reset();
    u_bsi_ctl.scan(1'b0, 32, 32'h0, dout);
    check(dout, ID);
    // every opcode, sample before extest so data is preloaded
    for (int k = 0; k < 16; k++) begin
      op = 4'(k ^ 1);
      u_bsi_ctl.scan(1'b1, 4, 32'(op), dout);
      check(dout, 32'(`BSI_IR_CAPTURE));
      din = $random(seed);
      u_bsi_ctl.scan(1'b0, len(op), din, dout);
      check(dout, want_dr(op, din));
      @(negedge clk_sys) core_out = N'($random(seed));
      core_oe = N'($random(seed));
      pad_in = N'($random(seed));
      repeat (6) @(negedge clk_sys);
      // pad data under high-z is masked, only the enables count there
      pads = 32'({test_mode, pad_oe, pad_out});
      if (op == `BSI_OP_HIGHZ) begin
        pads[N-1:0] = '0;
      end
      check(pads, want_pad(op, din));
    end
    // tms-only reset out of extest must restore idcode and normal pads
    u_bsi_ctl.scan(1'b1, 4, 32'(`BSI_OP_EXTEST), dout);
    check(dout, 32'(`BSI_IR_CAPTURE));
    u_bsi_ctl.tms_reset();
    u_bsi_ctl.scan(1'b0, 32, din, dout);
    check(dout, ID);
    repeat (6) @(negedge clk_sys);
    check(32'(test_mode), 32'h0);
    u_bsi_ctl.port_reset();
    u_bsi_ctl.scan(1'b0, 32, din, dout);
    check(dout, ID);
    report_and_stop();
  end
endmodule
